// ===== src/aws_seq.sv
// Waveform sequencer: table, block run control, set-value synthesis.
// Assumes one 40 MHz clock and an asynchronous alarm pin.
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module aws_seq
    import aws_pkg::*;
#(
    parameter logic [15:0] NOM_LEVEL = 16'hFFFF,
    parameter logic [39:0] AMP_TICKS_PER_LSB = 40'h0000010000
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Register port
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Device alarm pin
    input wire logic i_alarm,
    // Power stage side
    output logic [15:0] o_set_value,
    output logic o_set_is_voltage,
    output logic o_dc_input_on,
    output logic o_running
);
    aws_state_t state;            // Sequencer state
    logic alarm_m, alarm_s;       // Alarm synchroniser
    logic [6:0] start_seq;        // First sequence of block, 1-based
    logic [6:0] end_seq;          // Last sequence of block
    logic [15:0] cycles;          // Block repetitions, zero means endless
    logic target_volt;            // Target latched per run
    logic done_f, reject_f, alarm_f;
    logic [6:0] cur_seq;          // Sequence in play
    logic [15:0] cycle_cnt;       // Block passes completed
    logic [3:0] fcnt;             // Fetch slot counter
    aws_seq_t sq;                 // Loaded sequence
    logic [31:0] mem_q;
    logic [9:0] mem_ra;
    logic [1:0] dsel;             // Quantity being divided
    logic [5:0] dcnt;             // Divider bit counter
    logic [28:0] drem;
    logic [39:0] dnum, dquo;
    logic dneg;
    logic signed [41:0] step_amp, step_frq, step_dc;
    logic signed [41:0] acc_amp, acc_frq, acc_dc;
    logic [31:0] phase;           // Sine phase, full turn is 2^32
    logic [11:0] tick_div;        // Sample tick prescaler
    logic tick;
    logic [28:0] tick_n;          // Ticks elapsed in the sequence
    logic ac_off;

    // Table write address and clamped data
    logic tbl_wr;
    logic [9:0] tbl_wa;
    logic [31:0] tbl_wd;
    logic [31:0] w;
    assign w = i_wdata;
    assign tbl_wr = i_wr && i_addr[TABLE_BIT] && (i_addr[9:3] < 7'(SEQ_MAX));
    assign tbl_wa = 10'(i_addr[9:3]) * 10'(NUM_PARAM) + 10'(i_addr[2:0]);

    // Clamp fields on write so the table never holds an illegal value
    always_comb begin
        tbl_wd = w;
        case (i_addr[2:0])
            P_AC_START, P_AC_END: begin
                if (w > 32'(NOM_LEVEL >> 1)) tbl_wd = 32'(NOM_LEVEL >> 1); // see R10
            end
            P_F_START, P_F_END: begin
                if (w > 32'(FREQ_MAX)) tbl_wd = 32'(FREQ_MAX); // see R11
            end
            P_ANGLE: begin
                if (w > 32'(ANGLE_MAX)) tbl_wd = 32'(ANGLE_MAX); // see R12
            end
            P_DC_START, P_DC_END: begin
                if (w > 32'(NOM_LEVEL)) tbl_wd = 32'(NOM_LEVEL);
            end
            P_TIME: begin
                if (w < 32'(TIME_MIN)) tbl_wd = 32'(TIME_MIN); // see R9
                else if (w > 32'(TIME_MAX)) tbl_wd = 32'(TIME_MAX);
            end
            default: tbl_wd = w;
        endcase
    end

    // Sequence storage, one word per parameter, 100 sequences of 8 words
    aws_mem #(.WIDTH(32), .DEPTH(SEQ_MAX * NUM_PARAM), .AW(10)) u_mem ( // see R1
        .i_sys_clk(i_sys_clk),
        .i_we(tbl_wr),
        .i_waddr(tbl_wa),
        .i_wdata(tbl_wd),
        .i_raddr(mem_ra),
        .o_rdata(mem_q)
    );
    assign mem_ra = 10'(cur_seq - 7'h01) * 10'(NUM_PARAM) + 10'(fcnt[2:0]);

    // Alarm pin synchroniser
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            alarm_m <= 1'b0;
            alarm_s <= 1'b0;
        end else begin
            alarm_m <= i_alarm;
            alarm_s <= alarm_m;
        end
    end

    // Register writes decoded
    logic wr_ctrl, go, stop;
    assign wr_ctrl = i_wr && (i_addr == REG_CTRL);
    assign go = wr_ctrl && i_wdata[CTRL_START] && (state == S_IDLE) && !alarm_s;
    assign stop = wr_ctrl && i_wdata[CTRL_STOP];

    // Block limits and repetitions; each index clamped against the other
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            start_seq <= START_SEQ_RST;
            end_seq <= END_SEQ_RST;
            cycles <= CYCLES_RST;
        end else if (i_wr && state == S_IDLE) begin
            if (i_addr == REG_START_SEQ) begin
                if (i_wdata < 32'h1) start_seq <= 7'h01; // see R3
                else if (i_wdata > 32'(end_seq)) start_seq <= end_seq;
                else start_seq <= i_wdata[6:0];
            end
            if (i_addr == REG_END_SEQ) begin
                if (i_wdata > 32'(SEQ_MAX)) end_seq <= 7'(SEQ_MAX); // see R4
                else if (i_wdata < 32'(start_seq)) end_seq <= start_seq;
                else end_seq <= i_wdata[6:0];
            end
            if (i_addr == REG_CYCLES) begin
                cycles <= (i_wdata > 32'(CYCLES_MAX)) ? CYCLES_MAX : i_wdata[15:0]; // see R5
            end
        end
    end

    // Target can only change while idle, so a run never mixes targets
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            target_volt <= 1'b0;
        end else if (wr_ctrl && state == S_IDLE) begin
            target_volt <= i_wdata[CTRL_VOLT]; // see R6
        end
    end

    // Sample tick prescaler, runs only while playing
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tick_div <= '0;
        end else if (state != S_RUN || tick) begin
            tick_div <= '0;
        end else begin
            tick_div <= tick_div + 12'h001;
        end
    end
    assign tick = (tick_div == 12'(TICK_CYC - 1));

    // Load-time checks on the fetched sequence
    logic [15:0] dc_s_c, dc_e_c;
    logic [10:0] df_abs;
    logic [15:0] da_abs;
    logic f_bad, a_bad;
    always_comb begin
        // Keep DC inside amplitude margins at each end
        dc_s_c = sq.dc_start_level; // see R14
        if (dc_s_c < sq.ac_start_amplitude) dc_s_c = sq.ac_start_amplitude;
        if (dc_s_c > NOM_LEVEL - sq.ac_start_amplitude) dc_s_c = NOM_LEVEL - sq.ac_start_amplitude;
        dc_e_c = sq.dc_end_level;
        if (dc_e_c < sq.ac_end_amplitude) dc_e_c = sq.ac_end_amplitude;
        if (dc_e_c > NOM_LEVEL - sq.ac_end_amplitude) dc_e_c = NOM_LEVEL - sq.ac_end_amplitude;
        df_abs = (sq.end_frequency > sq.start_frequency) ?
            sq.end_frequency - sq.start_frequency : sq.start_frequency - sq.end_frequency;
        da_abs = (sq.ac_end_amplitude > sq.ac_start_amplitude) ?
            sq.ac_end_amplitude - sq.ac_start_amplitude :
            sq.ac_start_amplitude - sq.ac_end_amplitude;
        // df*ticks_per_s*10 below 93*ticks means under 9.3 Hz per second
        f_bad = (df_abs != 11'h0) && // see R15
            (40'(df_abs) * 40'(TICKS_PER_S * 10) < DF_MIN_X10 * 40'(sq.seq_time));
        a_bad = (da_abs != 16'h0) && // see R16
            (40'(da_abs) * AMP_TICKS_PER_LSB < 40'(sq.seq_time));
    end

    // Divider operands for the three interpolated quantities
    logic signed [16:0] dlt;
    logic [29:0] rsh;
    logic ge;
    always_comb begin
        case (dsel)
            2'd0: dlt = 17'(sq.ac_end_amplitude) - 17'(sq.ac_start_amplitude);
            2'd1: dlt = 17'(sq.end_frequency) - 17'(sq.start_frequency);
            default: dlt = 17'(sq.dc_end_level) - 17'(sq.dc_start_level);
        endcase
        rsh = {drem, dnum[39]};
        ge = rsh >= {1'b0, sq.seq_time};
    end

    // Main sequencer: fetch, check, compute slopes, play
    logic last_tick;
    assign last_tick = tick && (tick_n == sq.seq_time - 29'h1);
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= S_IDLE;
            cur_seq <= 7'h01;
            cycle_cnt <= '0;
            fcnt <= '0;
            sq <= '0;
            dsel <= '0;
            dcnt <= '0;
            drem <= '0;
            dnum <= '0;
            dquo <= '0;
            dneg <= 1'b0;
            step_amp <= '0;
            step_frq <= '0;
            step_dc <= '0;
        end else if (alarm_s || stop) begin
            state <= S_IDLE; // see R20
        end else begin
            case (state)
                S_IDLE: begin
                    if (go) begin
                        cur_seq <= start_seq; // see R2
                        cycle_cnt <= '0;
                        fcnt <= '0;
                        state <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    // Address issued in slot n, data captured in slot n+1
                    fcnt <= fcnt + 4'h1;
                    case (fcnt)
                        4'h1: sq.ac_start_amplitude <= mem_q[15:0];
                        4'h2: sq.ac_end_amplitude <= mem_q[15:0];
                        4'h3: sq.start_frequency <= mem_q[10:0];
                        4'h4: sq.end_frequency <= mem_q[10:0];
                        4'h5: sq.start_angle <= mem_q[8:0];
                        4'h6: sq.dc_start_level <= mem_q[15:0];
                        4'h7: sq.dc_end_level <= mem_q[15:0];
                        4'h8: sq.seq_time <= mem_q[28:0];
                        default: ;
                    endcase
                    if (fcnt == 4'h8) state <= S_CHECK;
                end
                S_CHECK: begin
                    sq.dc_start_level <= dc_s_c;
                    sq.dc_end_level <= dc_e_c;
                    dsel <= 2'd0;
                    dcnt <= '0;
                    if (f_bad || a_bad) begin
                        state <= S_IDLE;
                    end else begin
                        state <= S_DIV;
                    end
                end
                S_DIV: begin
                    // Restoring division of |delta|<<FRAC by the tick count
                    if (dcnt == 6'd0) begin
                        dneg <= dlt[16];
                        dnum <= 40'(dlt[16] ? -dlt : dlt) << FRAC;
                        drem <= '0;
                        dquo <= '0;
                        dcnt <= 6'd1;
                    end else begin
                        drem <= ge ? 29'(rsh - {1'b0, sq.seq_time}) : rsh[28:0];
                        dquo <= {dquo[38:0], ge};
                        dnum <= dnum << 1;
                        dcnt <= (dcnt == 6'd41) ? 6'd0 : dcnt + 6'd1;
                    end
                    if (dcnt == 6'd41) begin
                        case (dsel)
                            2'd0: step_amp <= dneg ? -42'(dquo) : 42'(dquo);
                            2'd1: step_frq <= dneg ? -42'(dquo) : 42'(dquo);
                            default: step_dc <= dneg ? -42'(dquo) : 42'(dquo);
                        endcase
                        dsel <= dsel + 2'd1;
                        if (dsel == 2'd2) state <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (last_tick) begin
                        fcnt <= '0;
                        state <= S_FETCH;
                        if (cur_seq < end_seq) begin
                            cur_seq <= cur_seq + 7'h01;
                        end else if (cycles == 16'h0 || cycle_cnt + 16'h1 < cycles) begin
                            cur_seq <= start_seq; // see R5
                            cycle_cnt <= cycle_cnt + 16'h1;
                        end else begin
                            cycle_cnt <= cycle_cnt + 16'h1;
                            state <= S_IDLE;
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // Status flags; start clears, a same-cycle event still sets
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            done_f <= 1'b0;
            reject_f <= 1'b0;
            alarm_f <= 1'b0;
        end else begin
            if (go) begin
                done_f <= 1'b0;
                reject_f <= 1'b0;
                alarm_f <= 1'b0;
            end
            if (state == S_RUN && last_tick && cur_seq >= end_seq &&
                cycles != 16'h0 && cycle_cnt + 16'h1 >= cycles) begin
                done_f <= 1'b1;
            end
            if (state == S_CHECK && (f_bad || a_bad)) reject_f <= 1'b1; // see R16
            if (alarm_s && state != S_IDLE) alarm_f <= 1'b1;
        end
    end

    // Interpolators restart each sequence, step every tick
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            acc_amp <= '0;
            acc_frq <= '0;
            acc_dc <= '0;
            tick_n <= '0;
        end else if (state != S_RUN) begin
            acc_amp <= 42'(sq.ac_start_amplitude) <<< FRAC; // see R19
            acc_frq <= 42'(sq.start_frequency) <<< FRAC;
            acc_dc <= 42'(sq.dc_start_level) <<< FRAC;
            tick_n <= '0;
        end else if (tick) begin
            acc_amp <= acc_amp + step_amp; // see R7
            acc_frq <= acc_frq + step_frq; // see R18
            acc_dc <= acc_dc + step_dc;
            tick_n <= tick_n + 29'h1; // see R9
        end
    end

    // Phase accumulator; increment tracks the swept frequency
    logic [59:0] ph_prod;
    assign ph_prod = 60'(acc_frq[39:0]) * 60'(PH_PER_HZ);
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            phase <= '0;
        end else if (state != S_RUN) begin
            phase <= 32'(sq.start_angle) * ANGLE_SCALE; // see R12
        end else if (tick) begin
            phase <= phase + ph_prod[55:24]; // see R17
        end
    end

    // Sine from a parabola per half wave; top phase bit gives the sign.
    // Shape error is a few percent, traded for no lookup table.
    logic [15:0] hp;
    logic [31:0] par;
    logic [14:0] smag;
    logic [30:0] acm;
    logic signed [18:0] lvl;
    assign hp = phase[30:15];
    assign par = 32'(hp) * 32'(17'h10000 - 17'(hp));
    assign smag = (par[31:15] > 17'h07FFF) ? 15'h7FFF : par[29:15];
    assign acm = 31'(acc_amp[39:24]) * 31'(smag);
    assign ac_off = (sq.start_frequency == 11'h0) && (sq.end_frequency == 11'h0);
    always_comb begin
        lvl = 19'(acc_dc[39:24]);
        if (!ac_off) begin // see R8
            if (phase[31]) lvl = lvl - 19'(acm[30:15]); // see R13
            else lvl = lvl + 19'(acm[30:15]);
        end
    end

    // Set value: refreshed while playing, zero on alarm or idle
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_set_value <= '0;
            o_dc_input_on <= 1'b0;
        end else if (alarm_s) begin
            o_set_value <= '0;
            o_dc_input_on <= 1'b0; // see R20
        end else if (state == S_RUN) begin
            o_dc_input_on <= 1'b1;
            if (lvl < 0) o_set_value <= '0; // see R21
            else if (lvl > 19'(NOM_LEVEL)) o_set_value <= NOM_LEVEL;
            else o_set_value <= lvl[15:0];
        end else if (state == S_IDLE) begin
            o_set_value <= '0;
            o_dc_input_on <= 1'b0;
        end
    end
    assign o_set_is_voltage = target_volt;
    assign o_running = (state != S_IDLE);

    // Read data, one cycle after the strobe; table and unmapped read zero
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            case (i_addr)
                REG_CTRL: o_rdata <= 32'(target_volt) << CTRL_VOLT;
                REG_START_SEQ: o_rdata <= 32'(start_seq);
                REG_END_SEQ: o_rdata <= 32'(end_seq);
                REG_CYCLES: o_rdata <= 32'(cycles);
                REG_STATUS: o_rdata <= (32'(o_running) << ST_RUN) | (32'(done_f) << ST_DONE)
                    | (32'(reject_f) << ST_REJECT) | (32'(alarm_f) << ST_ALARM)
                    | (32'(target_volt) << ST_VOLT) | (32'(cur_seq) << ST_IDX);
                REG_POSITION: o_rdata <= {cycle_cnt, 9'h0, cur_seq};
                default: o_rdata <= '0;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end
endmodule : aws_seq

// ===== src/aws_pkg.sv
// Constants and carrier types for the waveform sequencer.
// Assumes one 40 MHz clock.
// Overview of operation
// R1: Store 100 sequences, identical parameter set each
// R2: Run block first to last index ascending
// R3: First index limited to one..last index
// R4: Last index limited to first index..100
// R5: Repeat block set cycles, or endlessly
// R6: One common target, current or voltage
// R7: Linear DC ramp plus interpolated sine term
// R8: Zero start and end frequency: no sine
// R9: Sequence lasts its time, 0.1 ms..36000 s
// R10: AC amplitudes limited to half nominal
// R11: Frequencies limited to 0..1000 Hz
// R12: Start phase 0..359 whole degrees
// R13: Phase 180 starts with negative half
// R14: DC levels kept within amplitude margins
// R15: Reject frequency change below 9.3 per second
// R16: Reject amplitude change too small for time
// R17: Period count follows time times frequency
// R18: Rising frequency shortens successive periods
// R19: Each run restarts at its start level
// R20: Alarm halts sequence, DC input off
// R21: Interpolation and output update every tick
package aws_pkg;
    // Timing
    localparam int CLK_MHZ = 40;
    localparam int TICK_US = 100;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    localparam int TICKS_PER_S = 1000000 / TICK_US;
    localparam logic [28:0] TIME_MIN = 29'h0000001;
    localparam logic [28:0] TIME_MAX = 29'h15752A00;
    // Limits
    localparam int SEQ_MAX = 100;
    localparam int NUM_PARAM = 8;
    localparam logic [10:0] FREQ_MAX = 11'h3E8;
    localparam logic [8:0] ANGLE_MAX = 9'h167;
    localparam logic [15:0] CYCLES_MAX = 16'h03E7;
    localparam logic [39:0] DF_MIN_X10 = 40'h000000005D;
    localparam logic [31:0] ANGLE_SCALE = 32'h00B60B61;
    localparam logic [19:0] PH_PER_HZ = 20'h68DB9;
    localparam int FRAC = 24;
    // Register offsets
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_START_SEQ = 12'h001;
    localparam logic [11:0] REG_END_SEQ = 12'h002;
    localparam logic [11:0] REG_CYCLES = 12'h003;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_POSITION = 12'h005;
    localparam int TABLE_BIT = 11;
    // Field positions
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_VOLT = 2;
    localparam int ST_RUN = 0;
    localparam int ST_DONE = 1;
    localparam int ST_REJECT = 2;
    localparam int ST_ALARM = 3;
    localparam int ST_VOLT = 4;
    localparam int ST_IDX = 8;
    // Reset values
    localparam logic [6:0] START_SEQ_RST = 7'h01;
    localparam logic [6:0] END_SEQ_RST = 7'h64;
    localparam logic [15:0] CYCLES_RST = 16'h0001;
    // Parameter slots within one sequence
    localparam logic [2:0] P_AC_START = 3'h0;
    localparam logic [2:0] P_AC_END = 3'h1;
    localparam logic [2:0] P_F_START = 3'h2;
    localparam logic [2:0] P_F_END = 3'h3;
    localparam logic [2:0] P_ANGLE = 3'h4;
    localparam logic [2:0] P_DC_START = 3'h5;
    localparam logic [2:0] P_DC_END = 3'h6;
    localparam logic [2:0] P_TIME = 3'h7;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_FETCH = 3'b001,
        S_CHECK = 3'b010,
        S_DIV = 3'b011,
        S_RUN = 3'b100
    } aws_state_t;

    // One sequence as loaded for playback
    typedef struct packed {
        logic [15:0] ac_start_amplitude;
        logic [15:0] ac_end_amplitude;
        logic [10:0] start_frequency;
        logic [10:0] end_frequency;
        logic [8:0] start_angle;
        logic [15:0] dc_start_level;
        logic [15:0] dc_end_level;
        logic [28:0] seq_time;
    } aws_seq_t;
endpackage : aws_pkg

// ===== src/aws_mem.sv
// Table with one write port and a registered read port.
// Assumes one clock domain.
`timescale 1ns/1ps
module aws_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 800,
    parameter int AW = 10
) (
    // Clock
    input wire logic i_sys_clk,
    // Write port
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    // Read port
    input wire logic [AW-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);
    // Storage, no reset so it can map to block RAM
    logic [WIDTH-1:0] mem [DEPTH];

    // Write side
    always_ff @(posedge i_sys_clk) begin
        if (i_we && (32'(i_waddr) < DEPTH)) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // Read side, data one cycle after the address
    always_ff @(posedge i_sys_clk) begin
        if (32'(i_raddr) < DEPTH) begin
            o_rdata <= mem[i_raddr];
        end else begin
            o_rdata <= '0;
        end
    end
endmodule : aws_mem

// ===== dv/aws_stage_model.sv
// Power stage set-value input: records what the sequencer hands over.
// Assumes same clock as the sequencer; i_clr restarts the record.
`timescale 1ns/1ps
module aws_stage_model (
    // Clock and record clear
    input wire logic i_sys_clk,
    input wire logic i_clr,
    // Sequencer side
    input wire logic [15:0] i_set_value,
    input wire logic i_is_voltage,
    input wire logic i_dc_on,
    // Record
    output logic [31:0] o_on_cycles,
    output logic [15:0] o_min,
    output logic [15:0] o_max,
    output logic o_mix
);
    logic last_volt; // Target seen one cycle earlier
    // Only levels taken while the input is on count; idle zero is not load
    always_ff @(posedge i_sys_clk) begin
        last_volt <= i_is_voltage;
        if (i_clr) begin
            o_on_cycles <= 32'h0;
            o_min <= 16'hFFFF;
            o_max <= 16'h0;
            o_mix <= 1'b0;
        end else if (i_dc_on) begin
            o_on_cycles <= o_on_cycles + 32'h1;
            o_min <= (i_set_value < o_min) ? i_set_value : o_min;
            o_max <= (i_set_value > o_max) ? i_set_value : o_max;
            o_mix <= o_mix | (i_is_voltage !== last_volt);
        end
    end
endmodule : aws_stage_model

// ===== dv/aws_seq_checker.sv
// Port checker for the sequencer.
// Assumes one clock and the async active-low reset.
`timescale 1ns/1ps
module aws_seq_checker
    import aws_pkg::*;
(
    // Clock, reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Register port
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    // Alarm and stage side
    input wire logic i_alarm,
    input wire logic [15:0] o_set_value,
    input wire logic o_set_is_voltage,
    input wire logic o_dc_input_on,
    input wire logic o_running
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    // Start request accepted only at idle
    sequence start_req;
        i_wr && i_addr == REG_CTRL && i_wdata[CTRL_START] && !o_running && !i_alarm;
    endsequence
    chk_read_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("stray read data");
    chk_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) == 12'h006 |-> o_rdata == 32'h0)
        else $error("unmapped read");
    chk_idle_level: assert property (!o_running && !$past(o_running) |-> o_set_value == 16'h0 && !o_dc_input_on)
        else $error("idle output");
    chk_alarm_halt: assert property ($rose(i_alarm) |-> ##[1:4] (!o_running && !o_dc_input_on))
        else $error("no alarm halt");
    chk_target_fixed: assert property (o_running && $past(o_running) |-> $stable(o_set_is_voltage))
        else $error("target moved");
    chk_start_go: assert property (start_req |=> o_running ##1 o_running)
        else $error("start not taken");
    chk_load_first: assert property ($rose(o_dc_input_on) |-> $past(o_running, 8))
        else $error("early input on");
    chk_stop_off: assert property ($fell(o_running) |=> !o_dc_input_on)
        else $error("input left on");
endmodule : aws_seq_checker
bind aws_seq aws_seq_checker chk_u (.*);

// ===== dv/test_aws_seq.sv
// Self-checking bench for the sequencer.
// Assumes stage model and checker compiled first.
`timescale 1ns/1ps
module test_aws_seq;
    import aws_pkg::*;
    logic i_sys_clk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, i_alarm = 0, clr = 1;
    logic [11:0] i_addr = 12'h0;
    logic [31:0] i_wdata = 32'h0, d, ncyc;
    logic [15:0] sv, vmin, vmax;
    logic vt, on, run, mix;
    int n_mismatch = 0, compares = 0;
    // Rows: address, value written, value read back
    logic [11:0] ra [9] = '{12'h1, 12'h2, 12'h2, 12'h1, 12'h1, 12'h3, 12'h3, 12'h0, 12'h0};
    logic [31:0] rw [9] = '{32'h5, 32'h3, 32'hC8, 32'h0, 32'h96, 32'h0, 32'h4B0, 32'h4, 32'h0};
    logic [31:0] rx [9] = '{32'h5, 32'h5, 32'h64, 32'h1, 32'h64, 32'h0, 32'h3E7, 32'h4, 32'h0};
    aws_seq dut_u (.i_sys_clk, .i_nrst, .i_addr, .i_wdata,
        .i_wr, .i_rd, .o_rdata(d), .i_alarm, .o_set_value(sv),
        .o_set_is_voltage(vt), .o_dc_input_on(on), .o_running(run));
    aws_stage_model stage_u (.i_sys_clk, .i_clr(clr), .i_set_value(sv),
        .i_is_voltage(vt), .i_dc_on(on), .o_on_cycles(ncyc), .o_min(vmin), .o_max(vmax),
        .o_mix(mix));
    initial forever #12.5 i_sys_clk = ~i_sys_clk;
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge i_sys_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, v};
        @(posedge i_sys_clk) i_wr <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge i_sys_clk) {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_sys_clk) i_rd <= 1'b0;
        #1 v = d;
    endtask : rd
    task automatic print_verdict;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (90000) @(posedge i_sys_clk);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        logic [31:0] v;
        repeat (6) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        rd(REG_END_SEQ, v); check("end reset", v, 32'h64);
        rd(REG_CYCLES, v); check("cycles reset", v, 32'h1);
        for (int i = 0; i < 9; i++) begin
            wr(ra[i], rw[i]);
            rd(ra[i], v); check("index reg", v, rx[i]);
        end
        rd(12'h006, v); check("unmapped", v, 32'h0);
        // Flat levels 1000 then 3000, two ticks each; sequence 4 sweeps too slowly
        for (int p = 0; p < 8; p++) begin
            wr(12'h808 + p, p == 7 ? 2 : (p > 4 && p < 7) ? 1000 : 0);
            wr(12'h810 + p, p == 7 ? 2 : (p > 4 && p < 7) ? 3000 : 0);
            wr(12'h818 + p, p == 7 ? 10000 : p == 2 ? 1 : p == 3 ? 2 : 0);
        end
        rd(12'h808, v); check("table read", v, 32'h0);
        wr(REG_START_SEQ, 32'h2); wr(REG_END_SEQ, 32'h3); wr(REG_CYCLES, 32'h2);
        @(posedge i_sys_clk) clr <= 1'b0;
        wr(REG_CTRL, 32'h5);
        for (int k = 0; k < 20000 && !v[ST_DONE]; k++) rd(REG_STATUS, v);
        check("status done", v & 32'h17, 32'h12);
        check("lowest level", vmin, 16'h3E8);
        check("highest level", vmax, 16'hBB8);
        check("target mix", mix, 1'b0);
        check("on time", ncyc >= 32000 && ncyc <= 32800, 1'b1);
        rd(REG_POSITION, v); check("passes", v[31:16], 32'h2);
        wr(REG_END_SEQ, 32'h4); wr(REG_START_SEQ, 32'h4); wr(REG_CTRL, 32'h1);
        repeat (400) @(posedge i_sys_clk);
        rd(REG_STATUS, v); check("reject", v & 32'h5, 32'h4);
        wr(REG_START_SEQ, 32'h2); wr(REG_CYCLES, 32'h0); wr(REG_CTRL, 32'h1);
        repeat (2000) @(posedge i_sys_clk);
        i_alarm <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
        check("alarm halt", {run, on, sv}, 18'h0);
        wr(REG_CTRL, 32'h1);
        repeat (3) @(posedge i_sys_clk);
        check("start in alarm", run, 1'b0);
        rd(REG_STATUS, v); check("alarm flag", v[ST_ALARM], 1'b1);
        i_alarm <= 1'b0;
        print_verdict();
    end
endmodule : test_aws_seq
